// ===== logic/address_lookup_control_one.sv
// Address lookup control register with flush sequencing and source filters.
// Assumes an AXI4-Lite master, a lookup table that takes flush commands,
// and asynchronous per-port link status pins.
`timescale 1ns/10ps
module address_lookup_control_one
	import lookup_ctrl_pkg::*;
#(
	parameter int NUM_PORTS = PORT_COUNT
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_PORTS-1:0] link_up,
	input wire pkt_src_type pkt,
	output pkt_verdict_type verdict_ff,
	output logic learn_en_ff,
	output logic aging_en_ff,
	output logic fast_aging_ff,
	output flush_cmd_type flush_cmd,
	output logic flush_valid,
	input wire logic flush_ready
);
	if (NUM_PORTS != PORT_COUNT)
		$error("NUM_PORTS must equal the package port count");

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
	logic aw_held_ff, w_held_ff, nxt_aw_held, nxt_w_held;
	logic [11:0] aw_idx_ff, nxt_aw_idx;
	logic [31:0] wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
	logic [3:0] wstrb_ff, nxt_wstrb;
	logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [7:0] ctrl_ff, nxt_ctrl, ctrl_view;
	logic [1:0] scope_ff, nxt_scope;
	logic [MAC_W-1:0] mac_ff, nxt_mac;
	logic [PORT_COUNT-1:0] port_filt_ff, nxt_port_filt;
	logic all_req_ff, nxt_all_req, mstp_req_ff, nxt_mstp_req;
	logic [PORT_COUNT-1:0] link_pend_ff, nxt_link_pend, link_fall;
	logic [PORT_COUNT-1:0] link_s1_ff, link_s2_ff, link_prev_ff;
	flush_mode_type active_ff, nxt_active, start_mode;
	logic start, walk_busy, walk_done;
	logic [PORT_COUNT-1:0] start_ports;
	logic do_write, self_hit, all_view, mstp_view;
	pkt_verdict_type nxt_verdict;

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// ------------------------------------------------------------
	// Link status synchroniser and falling edge
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			link_s1_ff <= '0;
			link_s2_ff <= '0;
			link_prev_ff <= '0;
		end
		else
		begin
			link_s1_ff <= link_up;
			link_s2_ff <= link_s1_ff;
			link_prev_ff <= link_s2_ff;
		end
	end

	assign link_fall = link_prev_ff & ~link_s2_ff;

	// ------------------------------------------------------------
	// Flush launch: whole table, then spanning tree, then link loss
	// ------------------------------------------------------------
	assign all_view = all_req_ff || (walk_busy && active_ff == FLUSH_ALL);
	assign mstp_view = mstp_req_ff || (walk_busy && active_ff == FLUSH_MSTP);

	always_comb
	begin
		start = 1'b0;
		start_mode = FLUSH_ALL;
		start_ports = '0;
		if (!walk_busy)
		begin
			if (all_req_ff)
				start = 1'b1;
			else if (mstp_req_ff)
			begin
				start = 1'b1;
				start_mode = FLUSH_MSTP;
			end
			else if (|link_pend_ff)
			begin
				start = 1'b1;
				start_mode = FLUSH_PORT;
				start_ports = link_pend_ff;
			end
		end
	end

	flush_walker walker (
		.sys_clk(sys_clk),
		.rst(rst),
		.start(start),
		.mode(start_mode),
		.scope(scope_ff),
		.ports(start_ports),
		.cmd_ready(flush_ready),
		.cmd_ff(flush_cmd),
		.cmd_valid_ff(flush_valid),
		.busy_ff(walk_busy),
		.done_ff(walk_done)
	);

	// ------------------------------------------------------------
	// Register bus and control registers
	// ------------------------------------------------------------
	always_comb
	begin
		ctrl_view = ctrl_ff;
		ctrl_view[BIT_FLUSH_ALL] = all_view;
		ctrl_view[BIT_FLUSH_MSTP] = mstp_view;
		nxt_awready = awready_ff;
		nxt_wready = wready_ff;
		nxt_aw_held = aw_held_ff;
		nxt_w_held = w_held_ff;
		nxt_aw_idx = aw_idx_ff;
		nxt_wdata = wdata_ff;
		nxt_wstrb = wstrb_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_arready = arready_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		nxt_ctrl = ctrl_ff;
		nxt_scope = scope_ff;
		nxt_mac = mac_ff;
		nxt_port_filt = port_filt_ff;
		nxt_all_req = all_req_ff && !(start && start_mode == FLUSH_ALL);
		nxt_mstp_req = mstp_req_ff && !(start && start_mode == FLUSH_MSTP);
		nxt_link_pend = link_pend_ff & ~start_ports;
		if (ctrl_ff[BIT_LINK_FLUSH])
			nxt_link_pend = nxt_link_pend | link_fall;
		nxt_active = start ? start_mode : active_ff;
		do_write = aw_held_ff && w_held_ff && !bvalid_ff;
		if (s_axi_awvalid && awready_ff)
		begin
			nxt_aw_held = 1'b1;
			nxt_awready = 1'b0;
			nxt_aw_idx = s_axi_awaddr[ADDR_W-1:2];
		end
		if (s_axi_wvalid && wready_ff)
		begin
			nxt_w_held = 1'b1;
			nxt_wready = 1'b0;
			nxt_wdata = s_axi_wdata;
			nxt_wstrb = s_axi_wstrb;
		end
		if (do_write)
		begin
			nxt_aw_held = 1'b0;
			nxt_w_held = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = RESP_OKAY;
			case (aw_idx_ff)
				IDX_CTRL1:
				begin
					if (wstrb_ff[0])
					begin
						nxt_ctrl = wdata_ff[7:0];
						if (wdata_ff[BIT_FLUSH_ALL])
							nxt_all_req = 1'b1;
						if (wdata_ff[BIT_FLUSH_MSTP])
							nxt_mstp_req = 1'b1;
					end
				end
				IDX_CTRL2:
				begin
					if (wstrb_ff[0])
						nxt_scope = wdata_ff[SCOPE_LSB+1:SCOPE_LSB];
				end
				IDX_MAC_LO:
				begin
					for (int b = 0; b < 4; b++)
						if (wstrb_ff[b])
							nxt_mac[8*b+:8] = wdata_ff[8*b+:8];
				end
				IDX_MAC_HI:
				begin
					for (int b = 0; b < 2; b++)
						if (wstrb_ff[b])
							nxt_mac[32+8*b+:8] = wdata_ff[8*b+:8];
				end
				IDX_PORT_FILT:
				begin
					if (wstrb_ff[0])
						nxt_port_filt = wdata_ff[PORT_COUNT-1:0];
				end
				IDX_STATUS:
				begin
				end
				default:
					nxt_bresp = RESP_DECERR;
			endcase
		end
		if (bvalid_ff && s_axi_bready)
		begin
			nxt_bvalid = 1'b0;
			nxt_awready = 1'b1;
			nxt_wready = 1'b1;
		end
		if (s_axi_arvalid && arready_ff)
		begin
			nxt_arready = 1'b0;
			nxt_rvalid = 1'b1;
			nxt_rresp = RESP_OKAY;
			nxt_rdata = '0;
			case (s_axi_araddr[ADDR_W-1:2])
				IDX_CTRL1: nxt_rdata[7:0] = ctrl_view;
				IDX_CTRL2: nxt_rdata[SCOPE_LSB+1:SCOPE_LSB] = scope_ff;
				IDX_MAC_LO: nxt_rdata = mac_ff[31:0];
				IDX_MAC_HI: nxt_rdata[15:0] = mac_ff[47:32];
				IDX_PORT_FILT: nxt_rdata[PORT_COUNT-1:0] = port_filt_ff;
				IDX_STATUS: nxt_rdata = {15'h0000, walk_busy, link_pend_ff, link_s2_ff};
				default: nxt_rresp = RESP_DECERR;
			endcase
		end
		if (rvalid_ff && s_axi_rready)
		begin
			nxt_rvalid = 1'b0;
			nxt_arready = 1'b1;
		end
		nxt_ctrl[BIT_FLUSH_ALL] = 1'b0;
		nxt_ctrl[BIT_FLUSH_MSTP] = 1'b0;
	end

	// ------------------------------------------------------------
	// Packet source checks
	// ------------------------------------------------------------
	always_comb
	begin
		self_hit = (pkt.src_mac == mac_ff);
		nxt_verdict.valid = pkt.valid;
		nxt_verdict.drop_self = pkt.valid && self_hit && ctrl_ff[BIT_SELF_FILT]
			&& port_filt_ff[pkt.port];
		nxt_verdict.drop_mcast = pkt.valid && pkt.src_mac[MCAST_BIT]
			&& !ctrl_ff[BIT_MCAST_FWD];
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			arready_ff <= 1'b1;
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			aw_idx_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
			ctrl_ff <= CTRL1_RESET;
			scope_ff <= SCOPE_RESET;
			mac_ff <= MAC_RESET;
			port_filt_ff <= PORT_FILT_RESET;
			all_req_ff <= 1'b0;
			mstp_req_ff <= 1'b0;
			link_pend_ff <= '0;
			active_ff <= FLUSH_ALL;
			verdict_ff <= '0;
			learn_en_ff <= ~CTRL1_RESET[BIT_LEARN_DIS];
			aging_en_ff <= CTRL1_RESET[BIT_AGING];
			fast_aging_ff <= CTRL1_RESET[BIT_FAST_AGING];
		end
		else
		begin
			awready_ff <= nxt_awready;
			wready_ff <= nxt_wready;
			arready_ff <= nxt_arready;
			aw_held_ff <= nxt_aw_held;
			w_held_ff <= nxt_w_held;
			aw_idx_ff <= nxt_aw_idx;
			wdata_ff <= nxt_wdata;
			wstrb_ff <= nxt_wstrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			ctrl_ff <= nxt_ctrl;
			scope_ff <= nxt_scope;
			mac_ff <= nxt_mac;
			port_filt_ff <= nxt_port_filt;
			all_req_ff <= nxt_all_req;
			mstp_req_ff <= nxt_mstp_req;
			link_pend_ff <= nxt_link_pend;
			active_ff <= nxt_active;
			verdict_ff <= nxt_verdict;
			learn_en_ff <= ~nxt_ctrl[BIT_LEARN_DIS];
			aging_en_ff <= nxt_ctrl[BIT_AGING];
			fast_aging_ff <= nxt_ctrl[BIT_FAST_AGING];
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_learn_tracks_ctrl: assert property (do_write && aw_idx_ff == IDX_CTRL1
		&& wstrb_ff[0] |=> learn_en_ff == !$past(wdata_ff[BIT_LEARN_DIS]))
		else $error("learning enable does not follow the written control bit");
	a_self_drop_hit: assert property (pkt.valid && pkt.src_mac == mac_ff
		&& ctrl_ff[BIT_SELF_FILT] && port_filt_ff[pkt.port] |=> verdict_ff.drop_self)
		else $error("self-addressed packet not dropped");
	a_self_drop_off: assert property (!ctrl_ff[BIT_SELF_FILT] |=> !verdict_ff.drop_self)
		else $error("self filter acted with global enable clear");
	a_mcast_drop: assert property (pkt.valid && pkt.src_mac[MCAST_BIT]
		|=> verdict_ff.drop_mcast == !$past(ctrl_ff[BIT_MCAST_FWD]))
		else $error("multicast source verdict wrong");
	a_aging_outputs: assert property (do_write && aw_idx_ff == IDX_CTRL1
		&& wstrb_ff[0] |=> aging_en_ff == $past(wdata_ff[BIT_AGING])
		&& fast_aging_ff == $past(wdata_ff[BIT_FAST_AGING]))
		else $error("aging outputs do not follow the written control bits");
	a_all_flush_start: assert property (all_req_ff && !walk_busy && scope_ff != 2'h0
		|=> walk_busy && active_ff == FLUSH_ALL && flush_cmd.mode == FLUSH_ALL)
		else $error("table flush did not start");
	a_mstp_flush_start: assert property (mstp_req_ff && !all_req_ff && !walk_busy
		&& scope_ff != 2'h0 |=> walk_busy && flush_cmd.mode == FLUSH_MSTP)
		else $error("spanning tree flush did not start");
	a_trigger_readback: assert property (walk_busy && active_ff == FLUSH_ALL
		|-> ctrl_view[BIT_FLUSH_ALL])
		else $error("flush trigger reads 0 during its flush");
	a_trigger_clears: assert property (walk_done && !all_req_ff && !mstp_req_ff
		|-> !ctrl_view[BIT_FLUSH_ALL] && !ctrl_view[BIT_FLUSH_MSTP])
		else $error("flush trigger still reads 1 after its walk");
	a_scope_kinds: assert property (start |=> flush_cmd.dynamic_hit == $past(scope_ff[0])
		&& flush_cmd.static_hit == $past(scope_ff[1]))
		else $error("flush kinds do not follow the scope field");
	a_link_pending: assert property (ctrl_ff[BIT_LINK_FLUSH] && |link_fall
		|=> |link_pend_ff)
		else $error("link loss not queued for flushing");
	a_link_quiet: assert property (!ctrl_ff[BIT_LINK_FLUSH] && link_pend_ff == '0
		|=> link_pend_ff == '0)
		else $error("link loss queued while link flush is off");
endmodule

// ===== logic/lookup_ctrl_pkg.sv
// Constants, register map and carrier types for the lookup control block.
// Assumes one clock domain and AXI4-Lite register access with 32-bit data.
package lookup_ctrl_pkg;
	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int PORT_COUNT = 8;
	localparam int PORT_W = $clog2(PORT_COUNT);
	localparam int TABLE_DEPTH = 1024;
	localparam int IDX_W = $clog2(TABLE_DEPTH);
	localparam int ADDR_W = 14;
	localparam int MAC_W = 48;

	// ------------------------------------------------------------
	// Register indices; byte address is index times four
	// ------------------------------------------------------------
	localparam logic [11:0] IDX_CTRL1 = 12'h311;
	localparam logic [11:0] IDX_CTRL2 = 12'h312;
	localparam logic [11:0] IDX_MAC_LO = 12'h320;
	localparam logic [11:0] IDX_MAC_HI = 12'h321;
	localparam logic [11:0] IDX_PORT_FILT = 12'h322;
	localparam logic [11:0] IDX_STATUS = 12'h323;

	// ------------------------------------------------------------
	// Control 1 fields and reset values
	// ------------------------------------------------------------
	localparam int BIT_LEARN_DIS = 7;
	localparam int BIT_SELF_FILT = 6;
	localparam int BIT_FLUSH_ALL = 5;
	localparam int BIT_FLUSH_MSTP = 4;
	localparam int BIT_MCAST_FWD = 3;
	localparam int BIT_AGING = 2;
	localparam int BIT_FAST_AGING = 1;
	localparam int BIT_LINK_FLUSH = 0;
	localparam logic [7:0] CTRL1_RESET = 8'h0c;
	localparam int SCOPE_LSB = 2;
	localparam logic [1:0] SCOPE_RESET = 2'h0;
	localparam int SCOPE_DYN_BIT = 0;
	localparam int SCOPE_STATIC_BIT = 1;
	localparam logic [MAC_W-1:0] MAC_RESET = 48'h0000_0000_0000;
	localparam logic [PORT_COUNT-1:0] PORT_FILT_RESET = 8'h00;
	localparam int MCAST_BIT = 40;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {FLUSH_ALL, FLUSH_MSTP, FLUSH_PORT} flush_mode_type;

	typedef struct packed {
		logic [IDX_W-1:0] index;
		flush_mode_type mode;
		logic dynamic_hit;
		logic static_hit;
		logic [PORT_COUNT-1:0] ports;
	} flush_cmd_type;

	typedef struct packed {
		logic valid;
		logic [MAC_W-1:0] src_mac;
		logic [PORT_W-1:0] port;
	} pkt_src_type;

	typedef struct packed {
		logic valid;
		logic drop_self;
		logic drop_mcast;
	} pkt_verdict_type;
endpackage

// ===== logic/flush_walker.sv
// Walks every lookup table index and offers one flush command per entry.
// Assumes the table takes a command on each cycle that cmd_ready is high.
`timescale 1ns/10ps
module flush_walker
	import lookup_ctrl_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic start,
	input wire flush_mode_type mode,
	input wire logic [1:0] scope,
	input wire logic [PORT_COUNT-1:0] ports,
	input wire logic cmd_ready,
	output flush_cmd_type cmd_ff,
	output logic cmd_valid_ff,
	output logic busy_ff,
	output logic done_ff
);
	typedef enum logic {WALK_IDLE, WALK_RUN} walk_state_type;
	walk_state_type state_ff, nxt_state;
	flush_cmd_type nxt_cmd;
	logic nxt_cmd_valid, nxt_busy, nxt_done, last;

	assign last = (cmd_ff.index == IDX_W'(TABLE_DEPTH - 1));

	always_comb
	begin
		nxt_state = state_ff;
		nxt_cmd = cmd_ff;
		nxt_cmd_valid = cmd_valid_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		case (state_ff)
			WALK_IDLE:
			begin
				if (start)
				begin
					nxt_cmd.index = '0;
					nxt_cmd.mode = mode;
					nxt_cmd.dynamic_hit = scope[SCOPE_DYN_BIT];
					nxt_cmd.static_hit = scope[SCOPE_STATIC_BIT];
					nxt_cmd.ports = ports;
					if (scope == 2'h0)
						nxt_done = 1'b1;
					else
					begin
						nxt_state = WALK_RUN;
						nxt_cmd_valid = 1'b1;
						nxt_busy = 1'b1;
					end
				end
			end
			WALK_RUN:
			begin
				if (cmd_ready)
				begin
					if (last)
					begin
						nxt_state = WALK_IDLE;
						nxt_cmd_valid = 1'b0;
						nxt_busy = 1'b0;
						nxt_done = 1'b1;
					end
					else
						nxt_cmd.index = cmd_ff.index + IDX_W'(1);
				end
			end
			default:
			begin
				nxt_state = WALK_IDLE;
				nxt_cmd_valid = 1'b0;
				nxt_busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= WALK_IDLE;
			cmd_ff <= '0;
			cmd_valid_ff <= 1'b0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cmd_ff <= nxt_cmd;
			cmd_valid_ff <= nxt_cmd_valid;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_walk_kinds: assert property (cmd_valid_ff |-> (cmd_ff.dynamic_hit || cmd_ff.static_hit))
		else $error("flush command offered with no entry kind selected");
	a_walk_end: assert property (busy_ff && cmd_ready && last |=> done_ff && !busy_ff)
		else $error("walk did not finish after the last index");
endmodule

// ===== verification/address_lookup_control_one_tb_top.sv
// Self-checking testbench for the lookup control register block.
// Assumes the design package, the design top, a 200 MHz clock and AXI4-Lite.
`timescale 1ns/10ps
module address_lookup_control_one_tb_top import lookup_ctrl_pkg::*;;
	logic sys_clk;
	logic rst;
	logic [ADDR_W-1:0] s_axi_awaddr;
	logic [ADDR_W-1:0] s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp;
	logic [1:0] s_axi_rresp;
	logic [PORT_COUNT-1:0] link_up;
	pkt_src_type pkt;
	pkt_verdict_type verdict_ff;
	logic learn_en_ff, aging_en_ff, fast_aging_ff, flush_valid, flush_ready;
	flush_cmd_type flush_cmd;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;

	address_lookup_control_one #(.NUM_PORTS(PORT_COUNT)) uut (.sys_clk(sys_clk), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .link_up(link_up), .pkt(pkt),
		.verdict_ff(verdict_ff), .learn_en_ff(learn_en_ff), .aging_en_ff(aging_en_ff),
		.fast_aging_ff(fast_aging_ff), .flush_cmd(flush_cmd), .flush_valid(flush_valid),
		.flush_ready(flush_ready));

	// ------------------------------------------------------------
	// Clock, timeout and reporting
	// ------------------------------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Whole run is about 4500 cycles; the ceiling leaves ample margin
	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// ------------------------------------------------------------
	// Bus and stimulus tasks, entered just after a rising edge
	// ------------------------------------------------------------
	task automatic axi_write(input logic [11:0] idx, input logic [31:0] data,
		input logic [1:0] exp);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= data;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, exp);
	endtask

	task automatic read_expect(input logic [11:0] idx, input logic [31:0] exp,
		input logic [1:0] exp_resp);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!(s_axi_rvalid && s_axi_rready));
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, exp);
		check(s_axi_rresp, exp_resp);
	endtask

	task automatic send_pkt(input logic [MAC_W-1:0] mac, input logic [PORT_W-1:0] port,
		input logic [2:0] exp);
		pkt <= '{valid: 1'b1, src_mac: mac, port: port};
		@(posedge sys_clk);
		pkt.valid <= 1'b0;
		@(posedge sys_clk);
		check(verdict_ff, exp);
	endtask

	// Lets the table take every command and follows the walk to its end
	task automatic run_walk(input flush_mode_type m, input logic [1:0] sc, input logic [7:0] pm);
		int n;
		int k;
		n = 0;
		k = 0;
		flush_ready <= 1'b1;
		while (k < 3000)
		begin
			@(posedge sys_clk);
			k++;
			if (flush_valid && flush_ready)
			begin
				if (n == 0)
					check({flush_cmd.mode, flush_cmd.dynamic_hit, flush_cmd.static_hit},
						{m, sc[0], sc[1]});
				if (n == 0 && m == FLUSH_PORT)
					check(flush_cmd.ports, pm);
				check(flush_cmd.index, n[IDX_W-1:0]);
				n++;
			end
			else if (n > 0)
				break;
		end
		check(n, TABLE_DEPTH);
		flush_ready <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_reset();
		read_expect(IDX_CTRL1, 32'h0000_000c, RESP_OKAY);
		check({learn_en_ff, aging_en_ff, fast_aging_ff, flush_valid}, 4'hc);
		$display("test reset done");
	endtask

	task automatic test_aging_learn();
		axi_write(IDX_CTRL1, 32'h0000_0082, RESP_OKAY);
		check({learn_en_ff, aging_en_ff, fast_aging_ff}, 3'h1);
		read_expect(IDX_CTRL1, 32'h0000_0082, RESP_OKAY);
		axi_write(IDX_CTRL1, 32'h0000_000c, RESP_OKAY);
		check({learn_en_ff, aging_en_ff, fast_aging_ff}, 3'h6);
		$display("test aging and learning done");
	endtask

	task automatic test_filters();
		logic [7:0] ctl [6] = '{8'h4c, 8'h4c, 8'h0c, 8'h04, 8'h0c, 8'h04};
		logic [MAC_W-1:0] mac [6] = '{48'h0200_1122_3344, 48'h0200_1122_3344,
			48'h0200_1122_3344, 48'h0100_0000_0001, 48'h0100_0000_0001, 48'h0200_1122_3345};
		logic [PORT_W-1:0] prt [6] = '{3'h1, 3'h0, 3'h1, 3'h0, 3'h0, 3'h1};
		logic [2:0] exp [6] = '{3'h6, 3'h4, 3'h4, 3'h5, 3'h4, 3'h4};
		axi_write(IDX_MAC_LO, 32'h1122_3344, RESP_OKAY);
		axi_write(IDX_MAC_HI, 32'h0000_0200, RESP_OKAY);
		axi_write(IDX_PORT_FILT, 32'h0000_0002, RESP_OKAY);
		for (int i = 0; i < 6; i++)
		begin
			axi_write(IDX_CTRL1, {24'h0, ctl[i]}, RESP_OKAY);
			send_pkt(mac[i], prt[i], exp[i]);
		end
		axi_write(IDX_CTRL1, 32'h0000_000c, RESP_OKAY);
		$display("test packet filters done");
	endtask

	task automatic test_flush(input logic [1:0] sc, input logic [7:0] trig, input flush_mode_type m);
		axi_write(IDX_CTRL2, {28'h0, sc, 2'h0}, RESP_OKAY);
		axi_write(IDX_CTRL1, {24'h0, trig}, RESP_OKAY);
		read_expect(IDX_CTRL1, {24'h0, trig}, RESP_OKAY);
		run_walk(m, sc, 8'h00);
		repeat (2) @(posedge sys_clk);
		read_expect(IDX_CTRL1, 32'h0000_000c, RESP_OKAY);
		$display("test flush done");
	endtask

	task automatic test_scope_none();
		axi_write(IDX_CTRL2, 32'h0000_0000, RESP_OKAY);
		axi_write(IDX_CTRL1, 32'h0000_002c, RESP_OKAY);
		repeat (12)
		begin
			@(posedge sys_clk);
			check(flush_valid, 1'b0);
		end
		read_expect(IDX_CTRL1, 32'h0000_000c, RESP_OKAY);
		$display("test empty scope done");
	endtask

	task automatic test_link();
		axi_write(IDX_CTRL2, 32'h0000_0004, RESP_OKAY);
		link_up[3] <= 1'b0;
		repeat (10)
		begin
			@(posedge sys_clk);
			check(flush_valid, 1'b0);
		end
		link_up[3] <= 1'b1;
		repeat (5) @(posedge sys_clk);
		axi_write(IDX_CTRL1, 32'h0000_000d, RESP_OKAY);
		link_up[2] <= 1'b0;
		run_walk(FLUSH_PORT, 2'h1, 8'h04);
		link_up[2] <= 1'b1;
		$display("test link loss done");
	endtask

	task automatic test_unmapped();
		axi_write(12'h100, 32'h0000_00ff, RESP_DECERR);
		read_expect(12'h100, 32'h0000_0000, RESP_DECERR);
		read_expect(IDX_CTRL1, 32'h0000_000d, RESP_OKAY);
		read_expect(IDX_CTRL2, 32'h0000_0004, RESP_OKAY);
		read_expect(IDX_STATUS, 32'h0000_00ff, RESP_OKAY);
		$display("test unmapped done");
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		s_axi_awaddr = '0;
		s_axi_araddr = '0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		link_up = 8'hff;
		pkt = '0;
		flush_ready = 1'b0;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		test_reset();
		test_aging_learn();
		test_filters();
		test_flush(2'h1, 8'h2c, FLUSH_ALL);
		test_flush(2'h2, 8'h2c, FLUSH_ALL);
		test_flush(2'h3, 8'h1c, FLUSH_MSTP);
		test_scope_none();
		test_link();
		test_unmapped();
		print_verdict();
	end
endmodule
